// ### inc/pcsr_pkg.sv
`default_nettype none
package pcsr_pkg;

	// Register addresses on the management interface
	localparam logic [4:0] REG_PORT_CONFIGURATION = 5'h10;
	localparam logic [4:0] REG_PORT_STATUS_TWO    = 5'h11;

	// Configuration field positions
	localparam int CFG_FORCE_LINK_PASS   = 14;
	localparam int CFG_TX_DISABLE        = 13;
	localparam int CFG_SCRAMBLER_BYPASS  = 12;
	localparam int CFG_JABBER_DISABLE    = 10;
	localparam int CFG_HEARTBEAT_ENABLE  = 9;
	localparam int CFG_PAIR_LOOPBACK_DIS = 8;
	localparam int CFG_CARRIER_EXTEND    = 7;
	localparam int CFG_PREAMBLE_ENABLE   = 5;
	localparam int CFG_ALT_NEXT_PAGE     = 1;
	localparam logic [15:0] CFG_RESET    = 16'h0080;

	// Second status field positions
	localparam int ST2_SPEED_100   = 14;
	localparam int ST2_TX_ACTIVE   = 13;
	localparam int ST2_RX_ACTIVE   = 12;
	localparam int ST2_COLLISION   = 11;
	localparam int ST2_LINK_UP     = 10;
	localparam int ST2_FULL_DUPLEX = 9;
	localparam int ST2_AUTONEG     = 8;
	localparam int ST2_AN_COMPLETE = 7;
	localparam int ST2_POLARITY    = 5;
	localparam int ST2_PAUSE       = 4;
	localparam int ST2_ERROR       = 3;
	localparam logic [15:0] ST2_RESET = 16'h0000;

	// Management frame layout
	localparam logic [5:0] MGMT_PREAMBLE_BITS = 6'h20;
	localparam logic [4:0] MGMT_HEADER_LAST   = 5'h0D;
	localparam logic [4:0] MGMT_DATA_LAST     = 5'h0F;
	localparam logic [1:0] MGMT_START         = 2'h1;
	localparam logic [1:0] MGMT_OP_READ       = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE      = 2'h1;

	typedef enum logic [1:0] {
		PCSR_PRE  = 2'h0,
		PCSR_HDR  = 2'h1,
		PCSR_TA   = 2'h3,
		PCSR_DATA = 2'h2
	} pcsr_mgmt_state_e;

	// Live state from the transceiver core
	typedef struct packed {
		logic speed_100;
		logic tx_active;
		logic rx_active;
		logic collision;
		logic line_link_ok;
		logic full_duplex;
		logic autoneg_mode;
		logic an_complete;
		logic polarity_rev;
		logic pause_capable;
		logic error_seen;
	} pcsr_line_s;

	// Register write decoded from a management frame
	typedef struct packed {
		logic        valid;
		logic [4:0]  addr;
		logic [15:0] data;
	} pcsr_mgmt_wr_s;

endpackage
`default_nettype wire

// ### rtl/pcsr_mgmt_serial.sv
`timescale 1ns/1ps
`default_nettype none
module pcsr_mgmt_serial (
	// Clock and reset
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_reset,
	// Management pins
	input  wire logic                   i_mdc,
	input  wire logic                   i_mdio,
	output logic                        o_mdio,
	output logic                        o_mdio_oe,
	input  wire logic [4:0]             i_phy_addr,
	// Register side
	output logic [4:0]                  o_reg_addr,
	input  wire logic [15:0]            i_rd_data,
	output pcsr_pkg::pcsr_mgmt_wr_s     o_wr
);
	pcsr_pkg::pcsr_mgmt_state_e state_reg;
	logic        mdc_prev_reg;
	logic        mdc_rise;
	logic [5:0]  pre_cnt_reg;
	logic [4:0]  bit_cnt_reg;
	logic [13:0] hdr_reg;
	logic [13:0] hdr_next;
	logic [15:0] data_reg;
	logic        is_read_reg;

	assign mdc_rise = i_mdc & ~mdc_prev_reg;
	assign hdr_next = {hdr_reg[12:0], i_mdio};

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			mdc_prev_reg <= 1'b0;
		end else begin
			mdc_prev_reg <= i_mdc;
		end
	end

	// Bits are taken on the rising management clock edge
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_reg   <= pcsr_pkg::PCSR_PRE;
			pre_cnt_reg <= 6'h00;
			bit_cnt_reg <= 5'h00;
			hdr_reg     <= 14'h0000;
			data_reg    <= 16'h0000;
			is_read_reg <= 1'b0;
			o_reg_addr  <= 5'h00;
			o_mdio      <= 1'b0;
			o_mdio_oe   <= 1'b0;
			o_wr        <= '0;
		end else begin
			o_wr.valid <= 1'b0;
			if (mdc_rise) begin
				case (state_reg)
				pcsr_pkg::PCSR_PRE: begin
					if (i_mdio) begin
						if (pre_cnt_reg != pcsr_pkg::MGMT_PREAMBLE_BITS)
							pre_cnt_reg <= pre_cnt_reg + 6'h01;
					end else if (pre_cnt_reg ==
						pcsr_pkg::MGMT_PREAMBLE_BITS) begin
						hdr_reg     <= 14'h0000;
						bit_cnt_reg <= 5'h01;
						state_reg   <= pcsr_pkg::PCSR_HDR;
					end else begin
						pre_cnt_reg <= 6'h00;
					end
				end
				pcsr_pkg::PCSR_HDR: begin
					hdr_reg     <= hdr_next;
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == pcsr_pkg::MGMT_HEADER_LAST) begin
						bit_cnt_reg <= 5'h00;
						o_reg_addr  <= hdr_next[4:0];
						is_read_reg <= hdr_next[11:10] ==
							pcsr_pkg::MGMT_OP_READ;
						// Foreign address or bad code: wait for preamble
						if (hdr_next[13:12] == pcsr_pkg::MGMT_START &&
							hdr_next[9:5] == i_phy_addr &&
							(hdr_next[11:10] == pcsr_pkg::MGMT_OP_READ ||
							hdr_next[11:10] == pcsr_pkg::MGMT_OP_WRITE)) begin
							state_reg <= pcsr_pkg::PCSR_TA;
						end else begin
							pre_cnt_reg <= 6'h00;
							state_reg   <= pcsr_pkg::PCSR_PRE;
						end
					end
				end
				pcsr_pkg::PCSR_TA: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'h00) begin
						// Reading has no side effect on any bit
						data_reg  <= i_rd_data;
						o_mdio_oe <= is_read_reg;
						o_mdio    <= 1'b0;
					end else begin
						bit_cnt_reg <= 5'h00;
						state_reg   <= pcsr_pkg::PCSR_DATA;
						o_mdio      <= data_reg[15];
						if (is_read_reg)
							data_reg <= {data_reg[14:0], 1'b0};
					end
				end
				pcsr_pkg::PCSR_DATA: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					o_mdio      <= data_reg[15];
					if (is_read_reg)
						data_reg <= {data_reg[14:0], 1'b0};
					else
						data_reg <= {data_reg[14:0], i_mdio};
					if (bit_cnt_reg == pcsr_pkg::MGMT_DATA_LAST) begin
						o_mdio_oe   <= 1'b0;
						o_mdio      <= 1'b0;
						pre_cnt_reg <= 6'h00;
						state_reg   <= pcsr_pkg::PCSR_PRE;
						o_wr.valid  <= ~is_read_reg;
						o_wr.addr   <= o_reg_addr;
						o_wr.data   <= {data_reg[14:0], i_mdio};
					end
				end
				default: begin
					pre_cnt_reg <= 6'h00;
					o_mdio_oe   <= 1'b0;
					state_reg   <= pcsr_pkg::PCSR_PRE;
				end
				endcase
			end
		end
	end
endmodule // pcsr_mgmt_serial
`default_nettype wire

// ### rtl/phy_config_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module phy_config_status_regs (
	// Clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset,
	// Management serial interface
	input  wire logic                  i_mdc,
	input  wire logic                  i_mdio,
	output logic                       o_mdio,
	output logic                       o_mdio_oe,
	input  wire logic [4:0]            i_phy_addr,
	// Live state from the transceiver core
	input  wire pcsr_pkg::pcsr_line_s  i_line,
	// Receive path timing
	input  wire logic                  i_carrier,
	input  wire logic                  i_frame_sfd,
	// Negotiation page events
	input  wire logic                  i_page_rx_set,
	input  wire logic                  i_page_rx_read,
	input  wire logic                  i_mr_page_rx,
	input  wire logic                  i_base_page,
	input  wire logic                  i_base_page_read,
	// Core controls
	output logic                       o_link_pass,
	output logic                       o_tx_disable,
	output logic                       o_scrambler_bypass,
	output logic                       o_jabber_enable,
	output logic                       o_heartbeat_enable,
	output logic                       o_pair_loopback_on,
	output logic                       o_alt_next_page_enable,
	// Receive path to the MAC
	output logic                       o_crs,
	output logic                       o_rx_dv,
	output logic                       o_rxd_preamble,
	// Negotiation flags
	output logic                       o_page_received,
	output logic                       o_base_page_latched
);
	logic [15:0]             config_reg;
	logic [15:0]             status_two_reg;
	logic [15:0]             status_two_next;
	logic [15:0]             rd_data;
	logic [4:0]              reg_addr;
	pcsr_pkg::pcsr_mgmt_wr_s mgmt_wr;
	logic                    link_next;
	logic                    is_10mb;
	logic                    rx_dv_next;
	logic                    page_clr;

	// One decode serves both the read mux and the write path
	function automatic logic addr_is(input logic [4:0] a,
		input logic [4:0] r);
		addr_is = (a == r);
	endfunction

	pcsr_mgmt_serial u_mgmt (
		.i_ref_clk  (i_ref_clk),
		.i_reset    (i_reset),
		.i_mdc      (i_mdc),
		.i_mdio     (i_mdio),
		.o_mdio     (o_mdio),
		.o_mdio_oe  (o_mdio_oe),
		.i_phy_addr (i_phy_addr),
		.o_reg_addr (reg_addr),
		.i_rd_data  (rd_data),
		.o_wr       (mgmt_wr)
	);

	assign is_10mb = ~i_line.speed_100;

	// Host keeps reserved bits zero; stored as written
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			config_reg <= pcsr_pkg::CFG_RESET;
		end else if (mgmt_wr.valid &&
			addr_is(mgmt_wr.addr, pcsr_pkg::REG_PORT_CONFIGURATION)) begin
			config_reg <= mgmt_wr.data;
		end
	end

	// Forced pass overrides the line condition
	assign link_next = i_line.line_link_ok |
		config_reg[pcsr_pkg::CFG_FORCE_LINK_PASS];

	always_comb begin
		status_two_next = pcsr_pkg::ST2_RESET;
		status_two_next[pcsr_pkg::ST2_SPEED_100]   = i_line.speed_100;
		status_two_next[pcsr_pkg::ST2_TX_ACTIVE]   = i_line.tx_active;
		status_two_next[pcsr_pkg::ST2_RX_ACTIVE]   = i_line.rx_active;
		status_two_next[pcsr_pkg::ST2_COLLISION]   = i_line.collision;
		status_two_next[pcsr_pkg::ST2_LINK_UP]     = link_next;
		status_two_next[pcsr_pkg::ST2_FULL_DUPLEX] = i_line.full_duplex;
		status_two_next[pcsr_pkg::ST2_AUTONEG]     = i_line.autoneg_mode;
		status_two_next[pcsr_pkg::ST2_AN_COMPLETE] = i_line.an_complete;
		status_two_next[pcsr_pkg::ST2_POLARITY]    = i_line.polarity_rev;
		status_two_next[pcsr_pkg::ST2_PAUSE]       = i_line.pause_capable;
		status_two_next[pcsr_pkg::ST2_ERROR]       = i_line.error_seen;
	end

	// Live copy; management writes never reach it
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			status_two_reg <= pcsr_pkg::ST2_RESET;
		end else begin
			status_two_reg <= status_two_next;
		end
	end

	// Unmapped addresses read as zero
	always_comb begin
		rd_data = 16'h0000;
		if (addr_is(reg_addr, pcsr_pkg::REG_PORT_CONFIGURATION))
			rd_data = config_reg;
		else if (addr_is(reg_addr, pcsr_pkg::REG_PORT_STATUS_TWO))
			rd_data = status_two_reg;
	end

	// Core controls, registered so the core sees clean levels
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_link_pass            <= 1'b0;
			o_tx_disable           <= 1'b0;
			o_scrambler_bypass     <= 1'b0;
			o_jabber_enable        <= 1'b1;
			o_heartbeat_enable     <= 1'b0;
			o_pair_loopback_on     <= 1'b0;
			o_alt_next_page_enable <= 1'b0;
		end else begin
			o_link_pass <= link_next;
			o_tx_disable <= config_reg[pcsr_pkg::CFG_TX_DISABLE];
			o_scrambler_bypass <= i_line.speed_100 &
				config_reg[pcsr_pkg::CFG_SCRAMBLER_BYPASS];
			o_jabber_enable <= ~(is_10mb &
				config_reg[pcsr_pkg::CFG_JABBER_DISABLE]);
			o_heartbeat_enable <= is_10mb &
				config_reg[pcsr_pkg::CFG_HEARTBEAT_ENABLE];
			// Loopback exists only in 10 Mb/s half duplex anyway
			o_pair_loopback_on <= is_10mb & ~i_line.full_duplex &
				~config_reg[pcsr_pkg::CFG_PAIR_LOOPBACK_DIS];
			o_alt_next_page_enable <=
				config_reg[pcsr_pkg::CFG_ALT_NEXT_PAGE];
		end
	end

	// With preamble on, RX_DV opens with carrier
	assign rx_dv_next = config_reg[pcsr_pkg::CFG_PREAMBLE_ENABLE] ?
		(i_carrier | i_frame_sfd) : i_frame_sfd;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_rx_dv        <= 1'b0;
			o_rxd_preamble <= 1'b0;
			o_crs          <= 1'b0;
		end else begin
			o_rx_dv <= rx_dv_next;
			o_rxd_preamble <=
				config_reg[pcsr_pkg::CFG_PREAMBLE_ENABLE];
			// Extension only stretches carrier, never starts it early
			o_crs <= i_carrier | (o_crs & rx_dv_next & is_10mb &
				config_reg[pcsr_pkg::CFG_CARRIER_EXTEND]);
		end
	end

	// Extra clear causes only in alternate mode
	assign page_clr = i_page_rx_read |
		(config_reg[pcsr_pkg::CFG_ALT_NEXT_PAGE] &
		(~i_mr_page_rx | config_reg[pcsr_pkg::CFG_TX_DISABLE]));

	// A new page arriving with a clear still latches
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_page_received <= 1'b0;
		end else if (i_page_rx_set) begin
			o_page_received <= 1'b1;
		end else if (page_clr) begin
			o_page_received <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_base_page_latched <= 1'b0;
		end else if (!config_reg[pcsr_pkg::CFG_ALT_NEXT_PAGE]) begin
			o_base_page_latched <= 1'b0;
		end else if (i_base_page) begin
			o_base_page_latched <= 1'b1;
		end else if (i_base_page_read) begin
			o_base_page_latched <= 1'b0;
		end
	end
endmodule // phy_config_status_regs
`default_nettype wire

// ### sim/pcsr_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcsr_chk (
	// Clock and reset
	input wire logic                 i_ref_clk,
	input wire logic                 i_reset,
	// Watched inputs
	input wire pcsr_pkg::pcsr_line_s i_line,
	input wire logic                 i_carrier,
	input wire logic                 i_frame_sfd,
	input wire logic                 i_page_rx_set,
	// Watched outputs
	input wire logic                 o_link_pass,
	input wire logic                 o_tx_disable,
	input wire logic                 o_scrambler_bypass,
	input wire logic                 o_jabber_enable,
	input wire logic                 o_heartbeat_enable,
	input wire logic                 o_pair_loopback_on,
	input wire logic                 o_alt_next_page_enable,
	input wire logic                 o_crs,
	input wire logic                 o_rx_dv,
	input wire logic                 o_rxd_preamble,
	input wire logic                 o_page_received,
	input wire logic                 o_base_page_latched
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	// Three cycles of history cover either output latency
	sequence s_fast; i_line.speed_100[*3]; endsequence
	sequence s_rx_idle; (!i_carrier && !i_frame_sfd)[*3]; endsequence
	// Preamble copy lags its bit by one edge, so look one cycle ahead
	sequence s_pre_on;
		(o_rxd_preamble && i_carrier) ##1 o_rxd_preamble;
	endsequence
	sequence s_tx_off;
		(o_tx_disable && o_alt_next_page_enable && !i_page_rx_set)
		##1 (o_tx_disable && o_alt_next_page_enable);
	endsequence

	property p_link; i_line.line_link_ok[*3] |-> o_link_pass; endproperty
	property p_scr; (!i_line.speed_100)[*3] |-> !o_scrambler_bypass; endproperty
	property p_jab; s_fast |-> o_jabber_enable; endproperty
	property p_hb; s_fast |-> !o_heartbeat_enable; endproperty
	property p_lpb;
		(i_line.speed_100 || i_line.full_duplex)[*3] |-> !o_pair_loopback_on;
	endproperty
	property p_crs; i_carrier |=> o_crs; endproperty
	property p_idle; s_rx_idle |-> !o_crs && !o_rx_dv; endproperty
	property p_dv; i_frame_sfd[*3] |-> o_rx_dv; endproperty
	property p_pre; s_pre_on |-> o_rx_dv; endproperty
	property p_crs_ext; !i_carrier |=> (!o_crs || o_rx_dv); endproperty
	property p_crs_fast;
		(!i_carrier && i_line.speed_100) |=> !o_crs;
	endproperty
	property p_pg_set; i_page_rx_set |=> o_page_received; endproperty
	property p_pg_clr; s_tx_off |-> !o_page_received; endproperty
	property p_base;
		(!o_alt_next_page_enable)[*2] |-> !o_base_page_latched;
	endproperty

	a_link: assert property (p_link)
		else $error("link pass low with line up");
	a_scr: assert property (p_scr)
		else $error("scrambler bypass outside 100");
	a_jab: assert property (p_jab)
		else $error("jabber off at 100");
	a_hb: assert property (p_hb)
		else $error("heartbeat on at 100");
	a_lpb: assert property (p_lpb)
		else $error("loopback on outside 10 half");
	a_crs: assert property (p_crs)
		else $error("carrier not passed to crs");
	a_idle: assert property (p_idle)
		else $error("crs or rx_dv without carrier");
	a_dv: assert property (p_dv)
		else $error("rx_dv low during frame");
	a_pre: assert property (p_pre)
		else $error("rx_dv late with preamble on");
	a_crs_ext: assert property (p_crs_ext)
		else $error("crs stretched past rx_dv");
	a_crs_fast: assert property (p_crs_fast)
		else $error("crs stretched at 100");
	a_pg_set: assert property (p_pg_set)
		else $error("page flag not set");
	a_pg_clr: assert property (p_pg_clr)
		else $error("page flag kept with tx off");
	a_base: assert property (p_base)
		else $error("base page flag outside alternate mode");
endmodule // pcsr_chk

bind phy_config_status_regs pcsr_chk u_chk (
	.i_ref_clk, .i_reset, .i_line, .i_carrier, .i_frame_sfd,
	.i_page_rx_set, .o_link_pass, .o_tx_disable, .o_scrambler_bypass,
	.o_jabber_enable, .o_heartbeat_enable, .o_pair_loopback_on,
	.o_alt_next_page_enable, .o_crs, .o_rx_dv, .o_rxd_preamble,
	.o_page_received,
	.o_base_page_latched
);
`default_nettype wire

// ### sim/pcsr_station.sv
`timescale 1ns/1ps
`default_nettype none
module pcsr_station (
	// Clock
	input  wire logic i_ref_clk,
	// Device side of the management pins
	input  wire logic i_dev_mdio,
	input  wire logic i_dev_mdio_oe,
	output logic      o_mdc,
	output logic      o_mdio,
	// Read result
	output logic        o_done,
	output logic [15:0] o_word
);
	logic drv = 1'b1;
	logic bit_out = 1'b1;

	// Line has a pull-up, so a released line reads high
	assign o_mdio = i_dev_mdio_oe ? i_dev_mdio : (drv ? bit_out : 1'b1);

	initial begin
		o_mdc = 1'b0;
		o_done = 1'b0;
		o_word = 16'h0000;
	end

	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd);
		logic [63:0] f;
		if (ra == pcsr_pkg::REG_PORT_CONFIGURATION) wd = wd & 16'h77A2;
		f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
		for (int i = 63; i >= 0; i--) begin
			@(negedge i_ref_clk);
			o_mdc = 1'b0;
			drv = !(op == pcsr_pkg::MGMT_OP_READ && i < 18);
			bit_out = f[i];
			repeat (2) @(negedge i_ref_clk);
			if (i < 16) o_word[i] = o_mdio;
			o_mdc = 1'b1;
			@(negedge i_ref_clk);
		end
		drv = 1'b1;
		bit_out = 1'b1;
		if (op == pcsr_pkg::MGMT_OP_READ) begin
			o_done = 1'b1;
			@(negedge i_ref_clk);
			o_done = 1'b0;
		end
	endtask
endmodule // pcsr_station
`default_nettype wire

// ### sim/phy_config_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module phy_config_status_regs_test;
	logic                 i_ref_clk = 1'b0;
	logic                 i_reset = 1'b1;
	logic                 i_carrier = 1'b0;
	logic                 i_frame_sfd = 1'b0;
	logic                 i_page_rx_set = 1'b0;
	logic                 i_page_rx_read = 1'b0;
	logic                 i_mr_page_rx = 1'b0;
	logic                 i_base_page = 1'b0;
	logic                 i_base_page_read = 1'b0;
	logic [4:0]           i_phy_addr = 5'h05;
	pcsr_pkg::pcsr_line_s i_line = '0;
	logic                 mdc, mdio, dev_mdio, dev_oe, done;
	logic                 link_pass, tx_off, alt_np, rxd_pre;
	logic [15:0]          word, cfg;
	logic [31:0]          rnd = 32'h1FEC5729;
	logic [15:0]          exp_q[$];
	int                   fail_count = 0;
	int                   compares = 0;

	always #20 i_ref_clk = ~i_ref_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] st2(input pcsr_pkg::pcsr_line_s l,
		input logic f);
		logic [15:0] s;
		s = {1'h0, l[10:3], 1'h0, l[2:0], 3'h0};
		s[10] = s[10] | f;
		return s;
	endfunction

	task automatic report_and_stop;
		if (exp_q.size() != 0) fail_count++;
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] e);
		exp_q.push_back(e);
		mgr.frame(pcsr_pkg::MGMT_OP_READ, i_phy_addr, ra, 16'h0000);
	endtask

	task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] d);
		mgr.frame(pcsr_pkg::MGMT_OP_WRITE, pa, ra, d);
		repeat (3) @(negedge i_ref_clk);
	endtask

	// Receive and negotiation events run freely from the shared generator
	always @(negedge i_ref_clk) begin
		rnd = lfsr(rnd);
		i_carrier = rnd[0] | rnd[1];
		i_frame_sfd = rnd[2] & rnd[3];
		i_page_rx_set = rnd[4] & rnd[5] & rnd[6];
		i_page_rx_read = rnd[7] & rnd[8];
		i_mr_page_rx = rnd[9] | rnd[10];
		i_base_page = rnd[11] & rnd[12];
		i_base_page_read = rnd[13] & rnd[14];
	end

	always @(posedge i_ref_clk) begin
		if (done === 1'b1) begin
			compares++;
			if (exp_q.size() == 0 || word !== exp_q[0]) begin
				fail_count++;
				$display("mismatch at %0t: read data %h", $time, word);
			end
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end

	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_reset = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		rd(pcsr_pkg::REG_PORT_CONFIGURATION, pcsr_pkg::CFG_RESET);
		rd(pcsr_pkg::REG_PORT_STATUS_TWO, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			cfg = (k == 0) ? 16'h77A2 : (rnd[15:0] & 16'h77A2);
			i_line = pcsr_pkg::pcsr_line_s'(rnd[26:16]);
			wr(i_phy_addr, pcsr_pkg::REG_PORT_CONFIGURATION, cfg);
			wr(i_phy_addr, pcsr_pkg::REG_PORT_STATUS_TWO, 16'hFFFF);
			wr(i_phy_addr ^ 5'h01, pcsr_pkg::REG_PORT_CONFIGURATION, ~cfg);
			// Undefined operation code must leave the register alone
			mgr.frame(2'h3, i_phy_addr, pcsr_pkg::REG_PORT_CONFIGURATION, ~cfg);
			rd(pcsr_pkg::REG_PORT_CONFIGURATION, cfg);
			rd(pcsr_pkg::REG_PORT_STATUS_TWO, st2(i_line, cfg[14]));
			rd(5'h12, 16'h0000);
			compares++;
			if ({link_pass, tx_off, alt_np, rxd_pre} !== {
				i_line.line_link_ok |
				cfg[pcsr_pkg::CFG_FORCE_LINK_PASS],
				cfg[pcsr_pkg::CFG_TX_DISABLE],
				cfg[pcsr_pkg::CFG_ALT_NEXT_PAGE],
				cfg[pcsr_pkg::CFG_PREAMBLE_ENABLE]}) begin
				fail_count++;
				$display("mismatch at %0t: core controls", $time);
			end
		end
		report_and_stop;
	end

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		fail_count++;
		$display("mismatch at %0t: run did not finish", $time);
		report_and_stop;
	end

	pcsr_station mgr (
		.i_ref_clk     (i_ref_clk),
		.i_dev_mdio    (dev_mdio),
		.i_dev_mdio_oe (dev_oe),
		.o_mdc         (mdc),
		.o_mdio        (mdio),
		.o_done        (done),
		.o_word        (word)
	);

	phy_config_status_regs DUT (
		.i_ref_clk              (i_ref_clk),
		.i_reset                (i_reset),
		.i_mdc                  (mdc),
		.i_mdio                 (mdio),
		.o_mdio                 (dev_mdio),
		.o_mdio_oe              (dev_oe),
		.i_phy_addr             (i_phy_addr),
		.i_line                 (i_line),
		.i_carrier              (i_carrier),
		.i_frame_sfd            (i_frame_sfd),
		.i_page_rx_set          (i_page_rx_set),
		.i_page_rx_read         (i_page_rx_read),
		.i_mr_page_rx           (i_mr_page_rx),
		.i_base_page            (i_base_page),
		.i_base_page_read       (i_base_page_read),
		.o_link_pass            (link_pass),
		.o_tx_disable           (tx_off),
		.o_scrambler_bypass     (),
		.o_jabber_enable        (),
		.o_heartbeat_enable     (),
		.o_pair_loopback_on     (),
		.o_alt_next_page_enable (alt_np),
		.o_crs                  (),
		.o_rx_dv                (),
		.o_rxd_preamble         (rxd_pre),
		.o_page_received        (),
		.o_base_page_latched    ()
	);
endmodule // phy_config_status_regs_test
`default_nettype wire
